/* hdl/rgmii_pkg.sv */
package rgmii_pkg;
  // system clock and link clock rates in Hz
  localparam int CLK_HZ = 100_000_000;
  localparam int LINK_HZ_1000 = 125_000_000;
  localparam int LINK_HZ_100 = 25_000_000;
  localparam int LINK_HZ_10 = 2_500_000;
  // half periods of the generated receive clock, rounded down, at least one cycle
  localparam int HALF_1000_RAW = CLK_HZ / (2 * LINK_HZ_1000);
  localparam int HALF_100_RAW = CLK_HZ / (2 * LINK_HZ_100);
  localparam int HALF_10_RAW = CLK_HZ / (2 * LINK_HZ_10);
  localparam int HALF_1000 = (HALF_1000_RAW < 1) ? 1 : HALF_1000_RAW;
  localparam int HALF_100 = (HALF_100_RAW < 1) ? 1 : HALF_100_RAW;
  localparam int HALF_10 = (HALF_10_RAW < 1) ? 1 : HALF_10_RAW;
  localparam int DIV_W = 5;
  // link speed codes as carried in the in-band status
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  // in-band status nibble field positions
  localparam int STAT_LINK_BIT = 0;
  localparam int STAT_SPEED_LSB = 1;
  localparam int STAT_DUPLEX_BIT = 3;
  // stream word layouts
  localparam int TX_WORD_W = 10;
  localparam int TX_EN_BIT = 9;
  localparam int TX_ERR_BIT = 8;
  localparam int RX_WORD_W = 9;
  localparam int RX_ERR_BIT = 8;
  // buffer depth
  localparam logic [1:0] BUF_FULL = 2'h2;
  // receive side phase
  typedef enum logic {RX_STATUS = 1'b0, RX_FRAME = 1'b1} rx_state_e;
endpackage : rgmii_pkg

/* hdl/stream_if.sv */
`timescale 1ns/10ps
interface stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface : stream_if

/* hdl/two_entry_buf.sv */
`timescale 1ns/10ps
module two_entry_buf
  import rgmii_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  stream_if.snk up,
  stream_if.src dn
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } buf_s;

  buf_s st_ff;
  buf_s nxt_st;
  logic push;
  logic pop;

  // handshakes from occupancy, data straight from storage flops
  assign up.ready = (st_ff.cnt != BUF_FULL);
  assign dn.valid = (st_ff.cnt != 2'h0);
  assign dn.data = st_ff.mem[st_ff.rp];
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  // write, read and occupancy update
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = up.data;
      nxt_st.wp = ~st_ff.wp;
    end
    if (pop) begin
      nxt_st.rp = ~st_ff.rp;
    end
    case ({push, pop})
      2'b10: nxt_st.cnt = st_ff.cnt + 2'h1;
      2'b01: nxt_st.cnt = st_ff.cnt - 2'h1;
      default: nxt_st.cnt = st_ff.cnt;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : two_entry_buf

/* hdl/rgmii_phy_port.sv */
// What this block does
// - MAC drives transmit clock at 125, 25 or 2.5 MHz; device samples with it.
// - device delivers received frame nibbles on the four receive data lines.
// - outside frames, receive data lines carry speed, duplex and link-up status.
// - one receive control line carries data valid and receive error.
// - device makes receive clock at 25 or 2.5 MHz link rate, 50 MHz at gigabit, and times receive lines with it.
`timescale 1ns/10ps
module rgmii_phy_port
  import rgmii_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // transmit pins from the MAC
  input wire logic txc,
  input wire logic [3:0] txd,
  input wire logic tx_ctl,
  // received transmit bytes toward the line side
  output logic [7:0] tx_data,
  output logic tx_en,
  output logic tx_err,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_overflow,
  // receive bytes from the line side
  input wire logic [7:0] rx_data,
  input wire logic rx_err,
  input wire logic rx_valid,
  output logic rx_ready,
  // link status for in-band signalling
  input wire logic link_up,
  input wire logic full_duplex,
  input wire logic [1:0] link_speed,
  // receive pins toward the MAC
  output logic rxc,
  output logic [3:0] rxd,
  output logic rx_ctl
);
  typedef struct packed {
    logic [1:0] txc_s;
    logic [1:0][3:0] txd_s;
    logic [1:0] ctl_s;
    logic txc_prev;
    logic [3:0] lo_nib;
    logic lo_ctl;
    logic [TX_WORD_W-1:0] tx_word;
    logic tx_push;
    logic tx_ovf;
    logic [DIV_W-1:0] div_cnt;
    logic rxc;
    logic [3:0] rxd;
    logic rx_ctl;
    logic [3:0] hi_nib;
    logic hi_ctl;
    rx_state_e rx_st;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic tx_rise;
  logic tx_fall;
  logic div_zero;
  logic rx_pop;
  logic [3:0] status;
  logic [DIV_W-1:0] half_sel;

  stream_if #(.W(TX_WORD_W)) tx_in();
  stream_if #(.W(TX_WORD_W)) tx_out();
  stream_if #(.W(RX_WORD_W)) rx_in();
  stream_if #(.W(RX_WORD_W)) rx_out();

  // transmit words buffered so a stall downstream loses nothing until both entries are full
  two_entry_buf #(.W(TX_WORD_W)) u_tx_buf (
    .clk(clk),
    .nrst(nrst),
    .up(tx_in),
    .dn(tx_out)
  );

  // receive bytes buffered ahead of the serialiser
  two_entry_buf #(.W(RX_WORD_W)) u_rx_buf (
    .clk(clk),
    .nrst(nrst),
    .up(rx_in),
    .dn(rx_out)
  );

  // user side stream hookup
  assign tx_in.valid = st_ff.tx_push;
  assign tx_in.data = st_ff.tx_word;
  assign tx_out.ready = tx_ready;
  assign tx_valid = tx_out.valid;
  assign tx_data = tx_out.data[7:0];
  assign tx_en = tx_out.data[TX_EN_BIT];
  assign tx_err = tx_out.data[TX_ERR_BIT];
  assign tx_overflow = st_ff.tx_ovf;
  assign rx_in.valid = rx_valid;
  assign rx_in.data = {rx_err, rx_data};
  assign rx_ready = rx_in.ready;

  // edges of the synchronised transmit clock
  assign tx_rise = st_ff.txc_s[1] && !st_ff.txc_prev;
  assign tx_fall = !st_ff.txc_s[1] && st_ff.txc_prev;

  // receive clock divider and buffer pop on the falling toggle
  assign div_zero = (st_ff.div_cnt == '0);
  assign rx_pop = div_zero && st_ff.rxc && rx_out.valid;
  assign rx_out.ready = rx_pop;
  assign status = {full_duplex, link_speed, link_up};

  // half period for the current speed
  always_comb begin
    case (link_speed)
      SPEED_1000: half_sel = DIV_W'(HALF_1000 - 1);
      SPEED_100: half_sel = DIV_W'(HALF_100 - 1);
      SPEED_10: half_sel = DIV_W'(HALF_10 - 1);
      default: half_sel = DIV_W'(HALF_10 - 1);
    endcase
  end

  // next state of capture, transmit push and receive serialiser
  always_comb begin
    nxt_st = st_ff;
    // two-flop synchronisers on the transmit pins
    nxt_st.txc_s = {st_ff.txc_s[0], txc};
    nxt_st.txd_s = {st_ff.txd_s[0], txd};
    nxt_st.ctl_s = {st_ff.ctl_s[0], tx_ctl};
    nxt_st.txc_prev = st_ff.txc_s[1];
    nxt_st.tx_push = 1'b0;
    // rising edge: low nibble and enable
    if (tx_rise) begin
      nxt_st.lo_nib = st_ff.txd_s[1];
      nxt_st.lo_ctl = st_ff.ctl_s[1];
    end
    // falling edge: high nibble, error is enable xor control
    if (tx_fall) begin
      nxt_st.tx_word = {st_ff.lo_ctl, st_ff.lo_ctl ^ st_ff.ctl_s[1], st_ff.txd_s[1], st_ff.lo_nib};
      nxt_st.tx_push = st_ff.lo_ctl || st_ff.ctl_s[1];
    end
    // sticky when a word meets a full buffer
    if (st_ff.tx_push && !tx_in.ready) begin
      nxt_st.tx_ovf = 1'b1;
    end
    // receive clock toggles at each divider expiry
    if (div_zero) begin
      nxt_st.div_cnt = half_sel;
      nxt_st.rxc = ~st_ff.rxc;
      if (st_ff.rxc) begin
        // going low: launch the nibble the next rise carries
        if (rx_out.valid) begin
          nxt_st.rxd = rx_out.data[3:0];
          nxt_st.rx_ctl = 1'b1;
          nxt_st.hi_nib = rx_out.data[7:4];
          nxt_st.hi_ctl = ~rx_out.data[RX_ERR_BIT];
          nxt_st.rx_st = RX_FRAME;
        end else begin
          nxt_st.rxd = status;
          nxt_st.rx_ctl = 1'b0;
          nxt_st.hi_nib = status;
          nxt_st.hi_ctl = 1'b0;
          nxt_st.rx_st = RX_STATUS;
        end
      end else begin
        // going high: launch the nibble the next fall carries
        case (st_ff.rx_st)
          RX_FRAME: begin
            nxt_st.rxd = st_ff.hi_nib;
            nxt_st.rx_ctl = st_ff.hi_ctl;
          end
          RX_STATUS: begin
            nxt_st.rxd = status;
            nxt_st.rx_ctl = 1'b0;
          end
          default: begin
            nxt_st.rxd = status;
            nxt_st.rx_ctl = 1'b0;
          end
        endcase
      end
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt - DIV_W'(1);
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rxc = st_ff.rxc;
  assign rxd = st_ff.rxd;
  assign rx_ctl = st_ff.rx_ctl;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // receive clock half periods per speed
  AST_RXC_GIG: assert property ($rose(rxc) && $past(link_speed) == SPEED_1000 |=> !rxc)
    else $error("gigabit receive clock half period wrong");
  AST_RXC_100: assert property ($rose(rxc) && $past(link_speed) == SPEED_100 |-> ##1 rxc ##1 !rxc)
    else $error("100M receive clock half period wrong");
  AST_RXC_10: assert property ($rose(rxc) && $past(link_speed) == SPEED_10 |-> ##19 rxc ##1 !rxc)
    else $error("10M receive clock half period wrong");
  // frame nibbles on the receive pins
  AST_RX_LO: assert property (rx_pop |=> !rxc && rx_ctl && rxd == $past(rx_out.data[3:0]))
    else $error("low nibble or data valid missing after pop");
  AST_RX_HI: assert property (rx_pop && link_speed == SPEED_1000 |-> ##2 rxc &&
    rxd == $past(rx_out.data[7:4], 2) && rx_ctl == !$past(rx_out.data[RX_ERR_BIT], 2))
    else $error("high nibble or xor control wrong");
  AST_RX_STATUS: assert property (div_zero && rxc && !rx_out.valid |=> rxd == $past(status) && !rx_ctl)
    else $error("in-band status missing outside frame");
  AST_RX_CTL_IDLE: assert property (st_ff.rx_st == RX_STATUS && !rxc |-> !rx_ctl)
    else $error("receive control high outside a frame");
  // transmit capture into the buffer
  AST_TX_PUSH: assert property (tx_fall && st_ff.lo_ctl |=> st_ff.tx_push &&
    st_ff.tx_word[3:0] == $past(st_ff.lo_nib) && st_ff.tx_word[TX_EN_BIT])
    else $error("transmit byte not pushed on falling edge");
  AST_TX_IDLE: assert property (tx_fall && !st_ff.lo_ctl && !st_ff.ctl_s[1] |=> !st_ff.tx_push)
    else $error("idle transmit pushed a word");
  AST_TX_FLOW: assert property (st_ff.tx_push && tx_in.ready |=> tx_valid)
    else $error("accepted transmit word not offered");

  COV_RX_FRAME: cover property (rx_pop && link_speed == SPEED_1000);
  COV_RX_ERR: cover property (rx_pop && rx_out.data[RX_ERR_BIT]);
  COV_TX_ERR: cover property (st_ff.tx_push && st_ff.tx_word[TX_ERR_BIT]);
  COV_TX_OVF: cover property ($rose(tx_overflow));
endmodule : rgmii_phy_port

/* tb/mac_model.sv */
`timescale 1ns/10ps
module mac_model (
  input wire logic clk,
  output logic txc,
  output logic [3:0] txd,
  output logic tx_ctl,
  input wire logic rxc,
  input wire logic [3:0] rxd,
  input wire logic rx_ctl
);
  logic [8:0] rx_q[$];
  logic [3:0] lo = 4'h0;
  logic lo_ctl = 1'b0;
  logic prev_rxc = 1'b0;
  // idle: clock stands still low
  initial begin
    txc = 1'b0;
    txd = 4'h0;
    tx_ctl = 1'b0;
  end
  // one byte per 80 ns txc period, lines stable around each edge
  task automatic send(input logic [7:0] b, input logic en, input logic er);
    txd = b[3:0];
    tx_ctl = en;
    #10 txc = 1'b1;
    #30 txd = b[7:4];
    tx_ctl = en ^ er;
    #10 txc = 1'b0;
    #30;
  endtask : send
  // sample each rxc half, pair low half with the following high half
  always @(negedge clk) begin
    if (!rxc) begin
      lo <= rxd;
      lo_ctl <= rx_ctl;
    end else if (!prev_rxc && lo_ctl) begin
      rx_q.push_back({lo_ctl ^ rx_ctl, rxd, lo});
    end
    prev_rxc <= rxc;
  end
endmodule : mac_model

/* tb/rgmii_phy_side_port_bench.sv */
`timescale 1ns/10ps
module rgmii_phy_side_port_bench;
  import rgmii_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic txc, tx_ctl, tx_en, tx_err, tx_valid, tx_overflow, rx_ready, rxc, rx_ctl;
  logic [3:0] txd, rxd;
  logic [7:0] tx_data;
  logic tx_ready = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_err = 1'b0;
  logic rx_valid = 1'b0;
  logic link_up = 1'b0;
  logic full_duplex = 1'b0;
  logic [1:0] link_speed = 2'h0;
  int fail_count = 0;
  int total_checks = 0;
  int refused = 0;
  always #5 clk = ~clk;
  rgmii_phy_port DUT (.clk(clk), .nrst(nrst), .txc(txc), .txd(txd), .tx_ctl(tx_ctl), .tx_data(tx_data),
    .tx_en(tx_en), .tx_err(tx_err), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_overflow(tx_overflow),
    .rx_data(rx_data), .rx_err(rx_err), .rx_valid(rx_valid), .rx_ready(rx_ready), .link_up(link_up),
    .full_duplex(full_duplex), .link_speed(link_speed), .rxc(rxc), .rxd(rxd), .rx_ctl(rx_ctl));
  mac_model mac (.clk(clk), .txc(txc), .txd(txd), .tx_ctl(tx_ctl), .rxc(rxc), .rxd(rxd), .rx_ctl(rx_ctl));
  // compare one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // wait for a byte, compare, take it
  task automatic tx_take(input logic [9:0] exp);
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check({5'h0, tx_valid, tx_en, tx_err, tx_data}, {5'h0, 1'b1, exp});
    tx_ready = 1'b1;
    @(negedge clk);
    tx_ready = 1'b0;
    // let an edge pass so a following take does not re-raise ready at once
    @(negedge clk);
  endtask : tx_take
  // offer one byte, hold until taken; valid stays up for the caller to drop
  task automatic rx_put(input logic [7:0] b, input logic er);
    int n;
    n = 0;
    rx_data = b;
    rx_err = er;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1 && n < 200) begin
      refused++;
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask : rx_put
  // single bytes, error, carrier extend, dropped idle
  task automatic test_tx_single;
    mac.send(8'h5A, 1'b1, 1'b0);
    tx_take(10'h25A);
    mac.send(8'hC3, 1'b1, 1'b1);
    tx_take(10'h3C3);
    mac.send(8'h0F, 1'b0, 1'b1);
    tx_take(10'h10F);
    mac.send(8'h77, 1'b0, 1'b0);
    repeat (12) @(negedge clk);
    check(tx_valid, 1'b0);
    check(tx_overflow, 1'b0);
  endtask : test_tx_single
  // three bytes against a stalled consumer
  task automatic test_tx_overflow;
    mac.send(8'h11, 1'b1, 1'b0);
    mac.send(8'h22, 1'b1, 1'b0);
    mac.send(8'h33, 1'b1, 1'b0);
    repeat (12) @(negedge clk);
    check(tx_overflow, 1'b1);
    tx_take(10'h211);
    tx_take(10'h222);
    repeat (4) @(negedge clk);
    check(tx_valid, 1'b0);
  endtask : test_tx_overflow
  // in-band status and receive clock rate per speed
  task automatic test_status;
    int t, h;
    logic p;
    for (int s = 0; s < 3; s++) begin
      link_speed = s[1:0];
      link_up = 1'b1;
      full_duplex = s[0];
      h = (s == 0) ? HALF_10 : (s == 1) ? HALF_100 : HALF_1000;
      repeat (50) @(negedge clk);
      check(rxd, {full_duplex, link_speed, link_up});
      check(rx_ctl, 1'b0);
      t = 0;
      p = rxc;
      repeat (80) begin
        @(negedge clk);
        if (rxc !== p) t++;
        p = rxc;
      end
      check(t, 80 / h);
    end
  endtask : test_status
  // back to back receive bytes at one speed, order and error flag on the pins
  task automatic test_rx(input logic [1:0] spd);
    link_speed = spd;
    repeat (50) @(negedge clk);
    mac.rx_q.delete();
    refused = 0;
    rx_put(8'hA5, 1'b0);
    rx_put(8'h3C, 1'b1);
    rx_put(8'hF0, 1'b0);
    rx_put(8'h69, 1'b0);
    rx_valid = 1'b0;
    repeat (200) @(negedge clk);
    check(refused > 0, 1'b1);
    check(mac.rx_q.size(), 4);
    if (mac.rx_q.size() == 4) begin
      check(mac.rx_q[0], 9'h0A5);
      check(mac.rx_q[1], 9'h13C);
      check(mac.rx_q[2], 9'h0F0);
      check(mac.rx_q[3], 9'h069);
    end
  endtask : test_rx
  // counts and verdict
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    check({rxc, rxd, rx_ctl, tx_valid, tx_overflow}, 16'h0);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check(rx_ready, 1'b1);
    test_tx_single();
    test_tx_overflow();
    test_status();
    test_rx(SPEED_10);
    test_rx(SPEED_1000);
    summarize();
  end
  // watchdog
  initial begin
    #300000;
    fail_count++;
    summarize();
  end
endmodule : rgmii_phy_side_port_bench
